// file: hdl/atpwm_pkg.sv
//==============================================================
// Constants shared by the audio PWM timer block
//==============================================================
package atpwm_pkg;

  // ============================================================
  // Register byte offsets on the AHB-Lite bus
  // ============================================================
  localparam logic [4:0] OFF_CTRL0  = 5'h00;  // Run, clock select, audio select
  localparam logic [4:0] OFF_CTRL1  = 5'h04;  // Mode, output control, polarity
  localparam logic [4:0] OFF_CMPA   = 5'h08;  // Compare A value
  localparam logic [4:0] OFF_CMPB   = 5'h0C;  // Compare B value
  localparam logic [4:0] OFF_PERIOD = 5'h10;  // Period compare value
  localparam logic [4:0] OFF_STATUS = 5'h14;  // Match flags, write one to clear
  localparam logic [4:0] OFF_COUNT  = 5'h18;  // Counter, read only

  // ============================================================
  // Widths
  // ============================================================
  localparam int CNT_W = 10;  // Counter and A/B compare width
  localparam int PER_W = 8;   // Period compare width (counter bits 9..2)

  // ============================================================
  // Control 0 field positions
  // ============================================================
  localparam int C0_RUN_BIT   = 0;  // Counter run bit
  localparam int C0_CKSEL_LSB = 1;  // Counter clock select, 3 bits
  localparam int C0_AUDIO_BIT = 4;  // Audio PWM select

  // ============================================================
  // Control 1 field positions
  // ============================================================
  localparam int C1_CCLR_BIT  = 0;  // Counter clear select (no effect in PWM)
  localparam int C1_DPX_BIT   = 1;  // Duty/period swap bit
  localparam int C1_INV_BIT   = 2;  // Output invert bit
  localparam int C1_ACT_BIT   = 3;  // Output active level bit
  localparam int C1_IO_LSB    = 4;  // Output control field, 2 bits
  localparam int C1_MODE_LSB  = 6;  // Operating mode field, 2 bits

  // ============================================================
  // Status bit positions
  // ============================================================
  localparam int ST_A_BIT = 0;  // Compare A flag
  localparam int ST_B_BIT = 1;  // Compare B flag (audio mode only)
  localparam int ST_P_BIT = 2;  // Period match flag

  // ============================================================
  // Encodings and reset values
  // ============================================================
  localparam logic [1:0] MODE_PWM     = 2'h2;   // Operating mode selecting PWM
  localparam logic [1:0] IO_FORCE_LO  = 2'h0;   // Pin held low
  localparam logic [1:0] IO_FORCE_HI  = 2'h1;   // Pin held high
  localparam logic [2:0] CKSEL_DIV4   = 3'h0;   // System clock divided by four
  localparam logic [1:0] PRESCALE_TOP = 2'h3;   // Last count of the divide-by-four
  localparam logic [7:0] CTRL0_RST    = 8'h00;
  localparam logic [7:0] CTRL1_RST    = 8'h00;
  localparam logic [CNT_W-1:0] CMP_RST = 10'h000;
  localparam logic [CNT_W:0] FULL_PERIOD = 11'h400;  // 1024 clocks when compare is zero
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// file: hdl/atpwm_shadow_reg.sv
//==============================================================
// Compare value with a shadow copy and an active copy
//==============================================================
module atpwm_shadow_reg #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clk_en,
  // Write side
  input  wire logic             i_wr_en,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_load,
  // Values
  output logic      [WIDTH-1:0] o_shadow,
  output logic      [WIDTH-1:0] o_active
);

  // All state of this holder in one struct
  typedef struct packed {
    logic [WIDTH-1:0] shadow;  // Value last written by software
    logic [WIDTH-1:0] active;  // Value the comparator uses
  } atpwm_sh_type;

  atpwm_sh_type st_reg;
  atpwm_sh_type st_next;

  // ============================================================
  // Next state
  // ============================================================
  // A write in the same cycle as a load goes straight through, so the
  // newest value is never lost behind the older shadow copy
  always_comb begin
    st_next = st_reg;
    if (i_wr_en) begin
      st_next.shadow = i_wr_data;
    end
    if (i_load) begin
      st_next.active = i_wr_en ? i_wr_data : st_reg.shadow;
    end
  end

  // ============================================================
  // Registers
  // ============================================================
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_shadow = st_reg.shadow;
  assign o_active = st_reg.active;

endmodule // atpwm_shadow_reg

// file: hdl/atpwm_out_stage.sv
//==============================================================
// Pin stage: forcing, active level and inversion, registered
//==============================================================
module atpwm_out_stage (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_clk_en,
  // Waveform and controls
  input  wire logic       i_wave,
  input  wire logic [1:0] i_io_ctl,
  input  wire logic       i_act_level,
  input  wire logic       i_invert,
  // Pin
  output logic            o_pin
);

  // All state of the stage in one struct
  typedef struct packed {
    logic pin;  // Registered pin level
  } atpwm_os_type;

  atpwm_os_type st_reg;
  atpwm_os_type st_next;

  // ============================================================
  // Pin level
  // ============================================================
  always_comb begin
    st_next = st_reg;
    if (i_io_ctl == atpwm_pkg::IO_FORCE_LO) begin
      st_next.pin = 1'b0;
    end else if (i_io_ctl == atpwm_pkg::IO_FORCE_HI) begin
      st_next.pin = 1'b1;
    end else begin
      // Active phase shows the active level, then inversion on top
      st_next.pin = (i_wave ? i_act_level : ~i_act_level) ^ i_invert;
    end
  end

  // ============================================================
  // Register
  // ============================================================
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_pin = st_reg.pin;

endmodule // atpwm_out_stage

// file: hdl/atpwm_timer.sv
//==============================================================
//==============================================================
module atpwm_timer (
  // Clock, reset, enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // Speaker outputs
  output logic             o_audio_output_one,
  output logic             o_audio_output_two
);

  localparam int W = atpwm_pkg::CNT_W;
  localparam int P = atpwm_pkg::PER_W;

  // ============================================================
  // Elaboration check
  // ============================================================
  // The period compare must cover exactly the counter's top bits
  if (W != P + 2) begin : g_bad_width
    $error("atpwm_timer: counter width must be period width plus two");
  end

  // ============================================================
  // State
  // ============================================================
  typedef struct packed {
    logic [7:0]   ctrl0;     // Run, clock select, audio select
    logic [7:0]   ctrl1;     // Mode, output control, levels, swap
    logic [2:0]   flags;     // Sticky match flags
    logic [W-1:0] cnt;       // PWM counter
    logic [1:0]   pre;       // Divide-by-four prescaler
    logic         run_d;     // Run bit one cycle late, for edge
    logic         dp_wr;     // Write data phase pending
    logic [4:0]   dp_addr;   // Byte offset of the data phase
    logic [31:0]  rdata;     // Read data register
  } atpwm_st_type;

  atpwm_st_type st_reg;
  atpwm_st_type st_next;

  // Decoded controls
  logic         run;          // Counter run bit
  logic         audio;        // Audio mode in effect
  logic         pwm_on;       // Operating mode is PWM
  logic         dpx;          // Effective swap bit
  logic [1:0]   io_ctl;       // Output control field
  logic         run_rise;     // Run bit rising edge
  logic         tick;         // Counter clock enable
  // Compare values
  logic [W-1:0] a_sh;
  logic [W-1:0] a_act;
  logic [W-1:0] b_sh;
  logic [W-1:0] b_act;
  logic [P-1:0] p_sh;
  logic [P-1:0] p_act;
  // Limits and matches
  logic [W:0]   lim_p;        // Period-compare interval in clocks
  logic [W:0]   lim_a;        // Compare A interval in clocks
  logic [W-1:0] end_p;        // Counter value of a period match
  logic [W-1:0] end_a;        // Counter value of a compare A match in swap mode
  logic         hit_p;
  logic         hit_a;
  logic         hit_b;
  logic         clr;          // Counter clear
  logic         shadow_load;  // Active values take the shadow
  logic [W:0]   duty_one;     // Duty length for output one
  logic         wave_one;
  logic         wave_two;
  // Bus decode
  logic         addr_ok;      // Valid address phase
  logic         wr_a;
  logic         wr_b;
  logic         wr_p;

  // ============================================================
  // Control decode
  // ============================================================
  always_comb begin
    run    = st_reg.ctrl0[atpwm_pkg::C0_RUN_BIT];
    pwm_on = st_reg.ctrl1[atpwm_pkg::C1_MODE_LSB +: 2] == atpwm_pkg::MODE_PWM;
    audio  = pwm_on & st_reg.ctrl0[atpwm_pkg::C0_AUDIO_BIT];
    // Audio mode holds the swap bit at zero
    dpx    = st_reg.ctrl1[atpwm_pkg::C1_DPX_BIT] & ~audio;
    io_ctl = st_reg.ctrl1[atpwm_pkg::C1_IO_LSB +: 2];
    run_rise = run & ~st_reg.run_d;
    // Divide-by-four code ticks once in four cycles, others every cycle
    if (st_reg.ctrl0[atpwm_pkg::C0_CKSEL_LSB +: 3] == atpwm_pkg::CKSEL_DIV4) begin
      tick = st_reg.pre == atpwm_pkg::PRESCALE_TOP;
    end else begin
      tick = 1'b1;
    end
  end

  // ============================================================
  // Comparators
  // ============================================================
  // A zero compare lets the counter run its full 1024 clocks
  always_comb begin
    if (p_act == '0) begin
      lim_p = atpwm_pkg::FULL_PERIOD;
    end else begin
      lim_p = {1'b0, p_act, 2'b00};
    end
    if (a_act == '0) begin
      lim_a = atpwm_pkg::FULL_PERIOD;
    end else begin
      lim_a = {1'b0, a_act};
    end
    end_p = W'(lim_p - 11'h001);
    end_a = W'(lim_a - 11'h001);
    hit_p = run & pwm_on & tick & (st_reg.cnt == end_p);
    hit_a = run & pwm_on & tick & (st_reg.cnt == (dpx ? end_a : a_act));
    hit_b = run & audio & tick & (st_reg.cnt == b_act);
    // Clear select bit is not consulted here at all
    clr   = dpx ? hit_a : hit_p;
    // Normal mode loads at once; audio waits for the period match or the run edge
    shadow_load = ~audio | hit_p | run_rise;
    duty_one = dpx ? lim_p : {1'b0, a_act};
  end

  // ============================================================
  // Waveforms
  // ============================================================
  // Output one active from each clear until the duty count, two is its inverse outside audio; outputs idle when stopped
  always_comb begin
    wave_one = run & pwm_on & ~run_rise & ({1'b0, st_reg.cnt} < duty_one);
    if (audio) begin
      wave_two = run & ~run_rise & (st_reg.cnt < b_act);
    end else begin
      wave_two = run & pwm_on & ~run_rise & ~wave_one;
    end
  end

  // ============================================================
  // Bus decode
  // ============================================================
  always_comb begin
    addr_ok = i_clk_en & i_hsel & i_hready & i_htrans[1];
    wr_a = i_clk_en & st_reg.dp_wr & (st_reg.dp_addr == atpwm_pkg::OFF_CMPA);
    wr_b = i_clk_en & st_reg.dp_wr & (st_reg.dp_addr == atpwm_pkg::OFF_CMPB);
    wr_p = i_clk_en & st_reg.dp_wr & (st_reg.dp_addr == atpwm_pkg::OFF_PERIOD);
  end

  // ============================================================
  // Next state
  // ============================================================
  always_comb begin
    st_next = st_reg;
    st_next.run_d = run;
    // Counter runs on, whatever the output control says
    if (run_rise) begin
      st_next.cnt = '0;
      st_next.pre = '0;
    end else if (run & pwm_on) begin
      st_next.pre = st_reg.pre + 2'h1;
      if (clr) begin
        st_next.cnt = '0;
      end else if (tick) begin
        st_next.cnt = st_reg.cnt + W'(1);
      end
    end
    // Software writes: status bits clear by writing one
    st_next.dp_wr = 1'b0;
    if (st_reg.dp_wr) begin
      unique case (st_reg.dp_addr)
        atpwm_pkg::OFF_CTRL0:  st_next.ctrl0 = i_hwdata[7:0];
        atpwm_pkg::OFF_CTRL1:  st_next.ctrl1 = i_hwdata[7:0];
        atpwm_pkg::OFF_STATUS: st_next.flags = st_reg.flags & ~i_hwdata[2:0];
        default: ;  // Compare writes go to the holders; others ignored
      endcase
    end
    // Matches set flags after any clear, so a set is never lost
    if (hit_a) begin
      st_next.flags[atpwm_pkg::ST_A_BIT] = 1'b1;
    end
    if (hit_b) begin
      st_next.flags[atpwm_pkg::ST_B_BIT] = 1'b1;
    end
    if (hit_p) begin
      st_next.flags[atpwm_pkg::ST_P_BIT] = 1'b1;
    end
    // Address phase: capture writes, load read data now
    if (addr_ok) begin
      st_next.dp_wr   = i_hwrite;
      st_next.dp_addr = i_haddr[4:0];
      st_next.rdata   = '0;
      if (!i_hwrite && (i_haddr[31:5] == '0)) begin
        unique case (i_haddr[4:0])
          atpwm_pkg::OFF_CTRL0:  st_next.rdata = {24'h000000, st_reg.ctrl0};
          atpwm_pkg::OFF_CTRL1:  st_next.rdata = {24'h000000, st_reg.ctrl1};
          atpwm_pkg::OFF_CMPA:   st_next.rdata = {22'h000000, a_sh};
          atpwm_pkg::OFF_CMPB:   st_next.rdata = {22'h000000, b_sh};
          atpwm_pkg::OFF_PERIOD: st_next.rdata = {24'h000000, p_sh};
          atpwm_pkg::OFF_STATUS: st_next.rdata = {29'h00000000, st_reg.flags};
          atpwm_pkg::OFF_COUNT:  st_next.rdata = {22'h000000, st_reg.cnt};
          default:               st_next.rdata = '0;
        endcase
      end
      if (i_haddr[31:5] != '0) begin
        st_next.dp_wr = 1'b0;  // Unmapped: write dropped, reads zero
      end
    end
  end

  // ============================================================
  // Registers
  // ============================================================
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_reg       <= '0;
      st_reg.ctrl0 <= atpwm_pkg::CTRL0_RST;
      st_reg.ctrl1 <= atpwm_pkg::CTRL1_RST;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  // ============================================================
  // Compare holders
  // ============================================================
  atpwm_shadow_reg #(.WIDTH(W)) u_cmp_a (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_wr_en   (wr_a),
    .i_wr_data (i_hwdata[W-1:0]),
    .i_load    (shadow_load),
    .o_shadow  (a_sh),
    .o_active  (a_act)
  );

  atpwm_shadow_reg #(.WIDTH(W)) u_cmp_b (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_wr_en   (wr_b),
    .i_wr_data (i_hwdata[W-1:0]),
    .i_load    (shadow_load),
    .o_shadow  (b_sh),
    .o_active  (b_act)
  );

  atpwm_shadow_reg #(.WIDTH(P)) u_cmp_p (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_wr_en   (wr_p),
    .i_wr_data (i_hwdata[P-1:0]),
    .i_load    (shadow_load),
    .o_shadow  (p_sh),
    .o_active  (p_act)
  );

  // ============================================================
  // Output stages, same controls for both pins
  // ============================================================
  atpwm_out_stage u_out_one (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_wave      (wave_one),
    .i_io_ctl    (io_ctl),
    .i_act_level (st_reg.ctrl1[atpwm_pkg::C1_ACT_BIT]),
    .i_invert    (st_reg.ctrl1[atpwm_pkg::C1_INV_BIT]),
    .o_pin       (o_audio_output_one)
  );

  atpwm_out_stage u_out_two (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_wave      (wave_two),
    .i_io_ctl    (io_ctl),
    .i_act_level (st_reg.ctrl1[atpwm_pkg::C1_ACT_BIT]),
    .i_invert    (st_reg.ctrl1[atpwm_pkg::C1_INV_BIT]),
    .o_pin       (o_audio_output_two)
  );

  // ============================================================
  // Bus answers
  // ============================================================
  // A frozen block stalls the bus rather than miss a transfer
  assign o_hreadyout = i_clk_en;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = st_reg.rdata;

endmodule // atpwm_timer

// file: sim/atpwm_speaker.sv
//==============================================================
// Speaker model: integrates the drive on each coil
//==============================================================
module atpwm_speaker (
  // Clock
  input  wire logic        i_ref_clk,
  // Coil drive from the timer
  input  wire logic        i_pin_one,
  input  wire logic        i_pin_two,
  // Measuring window
  input  wire logic        i_clear,
  input  wire logic        i_count_en,
  // Clocks spent high on each coil
  output logic      [15:0] o_high_one,
  output logic      [15:0] o_high_two
);
  timeunit 1ns;
  timeprecision 1ps;
  // A speaker only hears the mean, so count high clocks
  always_ff @(posedge i_ref_clk) begin
    if (i_clear) begin
      o_high_one <= 16'h0000;
      o_high_two <= 16'h0000;
    end else if (i_count_en) begin
      o_high_one <= o_high_one + {15'h0000, i_pin_one};
      o_high_two <= o_high_two + {15'h0000, i_pin_two};
    end
  end
endmodule // atpwm_speaker

// file: sim/atpwm_timer_asserts.sv
//==============================================================
// Port checks for the audio PWM timer
//==============================================================
module atpwm_timer_asserts (
  // Clock, reset, enable
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_clk_en,
  // Bus
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  // Pins
  input wire logic        o_audio_output_one,
  input wire logic        o_audio_output_two
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr_pend;  // Write address phase taken
  logic [4:0] wr_addr;  // Its offset
  logic [7:0] c0_m;     // Control 0 as written
  logic [7:0] c1_m;     // Control 1 as written
  logic [1:0] calm;     // Edges since a write; the pins lag settings, so wait three
  // Mirror the controls off the bus, since the checker sees no internals
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 5'h00;
      c0_m    <= 8'h00;
      c1_m    <= 8'h00;
      calm    <= 2'h0;
    end else if (i_clk_en) begin
      wr_pend <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
      wr_addr <= i_haddr[4:0];
      c0_m    <= (wr_pend && wr_addr == atpwm_pkg::OFF_CTRL0) ? i_hwdata[7:0] : c0_m;
      c1_m    <= (wr_pend && wr_addr == atpwm_pkg::OFF_CTRL1) ? i_hwdata[7:0] : c1_m;
      calm    <= wr_pend ? 2'h0 : calm + {1'b0, calm != 2'h3};
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  bus_okay_a: assert property (o_hresp == 1'b0) else $error("response not OKAY");
  ready_en_a: assert property (o_hreadyout == i_clk_en) else $error("ready differs from enable");
  upper_zero_a: assert property (o_hrdata[31:10] == 22'h000000) else $error("upper read bits set");
  pin_freeze_a: assert property (!i_clk_en |=> $stable({o_audio_output_one, o_audio_output_two}))
    else $error("pins moved while disabled");
  reset_idle_a: assert property ($fell(i_sys_rst) |-> {o_audio_output_one, o_audio_output_two} == 2'h0)
    else $error("pins not low after reset");
  force_low_a: assert property (calm == 2'h3 && c1_m[5:4] == 2'h0 |->
    {o_audio_output_one, o_audio_output_two} == 2'h0) else $error("forced low not held");
  force_high_a: assert property (calm == 2'h3 && c1_m[5:4] == 2'h1 |->
    {o_audio_output_one, o_audio_output_two} == 2'h3) else $error("forced high not held");
  idle_level_a: assert property (calm == 2'h3 && c1_m[5] && !c0_m[0] |->
    o_audio_output_one == (c1_m[3] ~^ c1_m[2])) else $error("stopped pin not inactive");
endmodule // atpwm_timer_asserts

bind atpwm_timer atpwm_timer_asserts atpwm_timer_asserts_i (.i_ref_clk, .i_sys_rst, .i_clk_en, .i_hsel,
  .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata,
  .o_audio_output_one, .o_audio_output_two);

// file: sim/testbench.sv
//==============================================================
// Self-checking bench for the audio PWM timer
//==============================================================
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk, i_sys_rst, i_clk_en, i_hsel, i_hwrite;  // Clock, reset, bus controls
  logic [31:0] i_haddr, i_hwdata, o_hrdata;                        // Bus address and data
  logic [1:0]  i_htrans;
  logic        o_hreadyout, o_hresp, o_audio_output_one, o_audio_output_two;
  logic        cnt_en, cnt_clr;   // Speaker measuring window
  logic [15:0] hi_one, hi_two;    // Clocks high on each pin
  logic [31:0] exp_q[$];          // Expected results, oldest first
  logic [31:0] res, exp_v;        // Observed and expected result
  logic [15:0] smp;               // Voice sample
  event        res_ev;
  int          n_errors, check_count, seed;
  // Control 1 settings and high counts over 64 clocks at period 16, duty 5
  localparam logic [7:0]  C1_T [4] = '{8'h88, 8'h98, 8'hAC, 8'hA8};
  localparam logic [15:0] E1_T [4] = '{16'h0000, 16'h0040, 16'h002C, 16'h0014};
  localparam logic [15:0] E2_T [4] = '{16'h0000, 16'h0040, 16'h0014, 16'h002C};
  //============================================================
  // Clock, design and speaker
  //============================================================
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  atpwm_timer atpwm_timer_i (.i_ref_clk, .i_sys_rst, .i_clk_en, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata,
    .o_audio_output_one, .o_audio_output_two);
  atpwm_speaker atpwm_speaker_i (.i_ref_clk, .i_pin_one(o_audio_output_one), .i_pin_two(o_audio_output_two),
    .i_clear(cnt_clr), .i_count_en(cnt_en), .o_high_one(hi_one), .o_high_two(hi_two));
  //============================================================
  // Bus and measuring tasks
  //============================================================
  // One single transfer; each phase held until ready is sampled high
  task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    i_hsel   <= 1'b1;
    i_haddr  <= {27'h0000000, a};
    i_htrans <= atpwm_pkg::HTRANS_NONSEQ;
    i_hwrite <= wr;
    do begin @(posedge i_ref_clk); t++; end while (o_hreadyout !== 1'b1 && t < 50);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do begin @(posedge i_ref_clk); t++; end while (o_hreadyout !== 1'b1 && t < 50);
    q = o_hrdata;
    if (t >= 50) begin n_errors++; wrap_up(); end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  // Note the expected value first, then hand the result to the monitor
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h00000000, q);
    res = q;
    -> res_ev;
  endtask
  // Stop, program, clear flags, then start so the run edge reloads all
  task automatic cfg(input logic [7:0] c0, c1, input logic [9:0] a, b, input logic [7:0] p);
    wr(atpwm_pkg::OFF_CTRL0, 32'h00000000);
    wr(atpwm_pkg::OFF_CTRL1, {24'h000000, c1});
    wr(atpwm_pkg::OFF_CMPA, {22'h000000, a});
    wr(atpwm_pkg::OFF_CMPB, {22'h000000, b});
    wr(atpwm_pkg::OFF_PERIOD, {24'h000000, p});
    wr(atpwm_pkg::OFF_STATUS, 32'h00000007);
    wr(atpwm_pkg::OFF_CTRL0, {24'h000000, c0});
  endtask
  // A window of whole periods holds whole duties, whatever its phase
  task automatic meas(input int n, input logic [15:0] e1, e2);
    exp_q.push_back({e1, e2});
    repeat (12) @(posedge i_ref_clk);
    cnt_clr <= 1'b1;
    @(posedge i_ref_clk);
    cnt_clr <= 1'b0;
    cnt_en  <= 1'b1;
    repeat (n) @(posedge i_ref_clk);
    cnt_en <= 1'b0;
    @(posedge i_ref_clk);
    res = {hi_one, hi_two};
    -> res_ev;
    $display("test window of %0d clocks done at %0t", n, $time);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Monitor: compare each result with the oldest note
  always @(res_ev) begin
    exp_v = exp_q.pop_front();
    check_count++;
    if (res !== exp_v) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, res, exp_v);
    end
  end
  // Watchdog against a hung design
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    n_errors++;
    wrap_up();
  end
  //============================================================
  // Main sequence
  //============================================================
  initial begin
    {n_errors, check_count, seed} = {32'd0, 32'd0, 32'd23};
    {i_sys_rst, i_clk_en, i_hsel, i_hwrite, cnt_en, cnt_clr} = 6'h30;
    {i_haddr, i_hwdata, i_htrans} = 66'h0;
    repeat (5) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    wr(5'h1C, 32'h000003FF);
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h00000000);
    smp = 16'($random(seed));
    wr(atpwm_pkg::OFF_CMPB, {22'h000000, smp[9:0]});
    rd(atpwm_pkg::OFF_CMPB, {22'h000000, smp[9:0]});
    cfg(8'h03, 8'hA8, 10'h005, 10'h000, 8'h04);
    meas(64, 16'h0014, 16'h002C);
    rd(atpwm_pkg::OFF_STATUS, 32'h00000005);
    cfg(8'h03, 8'hAB, 10'h00C, 10'h000, 8'h02);
    meas(48, 16'h0020, 16'h0010);
    cfg(8'h03, 8'hA9, 10'h12C, 10'h000, 8'h00);
    meas(1024, 16'h012C, 16'h02D4);
    cfg(8'h01, 8'hA8, 10'h001, 10'h000, 8'h01);
    meas(64, 16'h0010, 16'h0030);
    cfg(8'h03, 8'hA8, 10'h005, 10'h000, 8'h04);
    for (int i = 0; i < 4; i++) begin
      wr(atpwm_pkg::OFF_STATUS, 32'h00000007);
      wr(atpwm_pkg::OFF_CTRL1, {24'h000000, C1_T[i]});
      meas(64, E1_T[i], E2_T[i]);
      rd(atpwm_pkg::OFF_STATUS, 32'h00000005);
    end
    cfg(8'h13, 8'hAA, {2'h0, smp[15:8]}, {2'h0, ~smp[15:8]}, 8'h40);
    meas(512, {7'h00, smp[15:8], 1'b0}, {7'h00, ~smp[15:8], 1'b0});
    cfg(8'h13, 8'hA8, {2'h0, smp[15] ? smp[14:7] : 8'h00}, {2'h0, smp[15] ? 8'h00 : ~smp[14:7]}, 8'h40);
    meas(512, {7'h00, smp[15] ? smp[14:7] : 8'h00, 1'b0}, {7'h00, smp[15] ? 8'h00 : ~smp[14:7], 1'b0});
    i_clk_en <= 1'b0;
    fork
      rd(atpwm_pkg::OFF_STATUS, 32'h00000007);
      begin repeat (9) @(posedge i_ref_clk); i_clk_en <= 1'b1; end
    join
    cfg(8'h13, 8'hA8, 10'h008, 10'h000, 8'h40);
    wr(atpwm_pkg::OFF_CMPA, 32'h000000F0);
    meas(200, 16'h0000, 16'h0000);
    wr(atpwm_pkg::OFF_CTRL0, 32'h00000000);
    repeat (8) @(posedge i_ref_clk);
    wrap_up();
  end
endmodule // testbench
